// File: verilog/frontend_ctrl_pkg.sv
/*
  Shared constants and carrier types for the front end control block:
  register offsets, field positions, strap-selected defaults, serial frame
  layout and reset timing. Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package frontend_ctrl_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] SOFT_RESET_CONTROL_ADDR = 7'h00;
  localparam logic [ADDR_W-1:0] ADC_POWER_OPTION_ADDR   = 7'h07;
  localparam logic [ADDR_W-1:0] TEST_MODE_CONTROL_ADDR  = 7'h0D;
  localparam logic [ADDR_W-1:0] RX_BIAS_ADJUST_ADDR     = 7'h13;

  // soft_reset_control fields
  localparam int SOFT_RESET_BIT    = 5;
  localparam int STRAP_CONFIG_BIT  = 1;
  localparam int STRAP_DUPLEX_BIT  = 0;
  // adc_power_option fields
  localparam int ADC_LOW_POWER_BIT = 4;
  // test_mode_control fields
  localparam int ANALOG_LOOP_BIT   = 7;
  localparam int DIGITAL_LOOP_BIT  = 6;
  localparam int RX_TRISTATE_BIT   = 5;
  // rx_bias_adjust fields
  localparam int COARSE_BIAS_MSB   = 7;
  localparam int COARSE_BIAS_LSB   = 5;
  localparam int FINE_BIAS_MSB     = 4;
  localparam int FINE_BIAS_LSB     = 3;
  localparam int CONV_BIAS_MSB     = 2;
  localparam int CONV_BIAS_LSB     = 0;

  localparam logic [2:0] CONV_BIAS_LOW_POWER = 3'h3;

  // adc option defaults indexed by {duplex strap, config strap}; the other defaults are fixed
  localparam logic [DATA_W-1:0] ADC_OPTION_DEFAULT [4] = '{8'h00, 8'h10, 8'h00, 8'h00};
  localparam logic [DATA_W-1:0] TEST_MODE_DEFAULT      = 8'h00;
  localparam logic [DATA_W-1:0] RX_BIAS_DEFAULT        = 8'h00;
  localparam logic [DATA_W-1:0] SOFT_RESET_DEFAULT     = 8'h00;

  // serial frame: read flag, 7-bit address, 8 data bits, msb first
  localparam int FRAME_BITS  = 16;
  localparam int HEADER_BITS = 8;

  localparam int CLK_PERIOD_NS     = 50;
  localparam int HW_RESET_MIN_NS   = 50;
  localparam int HW_RESET_MIN_CYC  =
    (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
    (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic       full_duplex;
    logic       config_sel;
  } strap_type;

  typedef struct packed {
    logic [2:0] coarse;
    logic [1:0] fine;
    logic [2:0] conv;
  } bias_settings_type;

  typedef enum logic [0:0] {
    PH_HEADER,
    PH_DATA
  } spi_phase_type;

endpackage

`default_nettype wire

// File: verilog/frontend_reset_bias_loopback_ctrl.sv
/*
  Control logic of the modem front end: strap-selected register defaults,
  hardware and software reset sequencing, receive bias settings and the
  loop-back and receive three-state test modes, reached over the serial
  configuration port. Assumes all pins, including the serial clock, are
  synchronous to ref_clk and that the serial clock runs well below it.
*/
// Notes on behaviour
// (RL1) bias register: coarse 7:5, fine 4:3, converter 2:0
// (RL2) bias register resets to all zeros
// (RL3) converter low-power bit equals converter bias 011
// (RL4) duplex strap low half, high full duplex
// (RL5) register defaults chosen from both strap pins
// (RL6) serial port ignored while its select is high
// (RL7) hardware or soft reset restores strap-defined state
// (RL8) calibration starts after hardware reset only
// (RL9) resets never flush transmit interpolation path
// (RL10) host holds reset pin low at least 50 ns
// (RL11) registers take defaults as soon as pin falls
// (RL12) calibration begins when reset pin rises
// (RL13) host keeps reset low 10 ms after power-up
// (RL14) analog loop-back feeds converter words to transmit path
// (RL15) digital loop-back drives receive port from transmit port
// (RL16) receive three-state bit floats receive port
// (RL17) soft reset bit clears itself after acting
`timescale 1ns/1ps
`default_nettype none

module frontend_reset_bias_loopback_ctrl
  import frontend_ctrl_pkg::*;
#(
  parameter int CONV_W = 12,
  parameter int PORT_W = 6
) (
  input  wire logic              ref_clk,            // device digital clock
  input  wire logic              reset,              // system reset, sync, active high
  input  wire logic              hw_reset_n,         // hardware reset pin, active low
  input  wire logic              duplex_strap,       // low half, high full duplex
  input  wire logic              default_set_strap,  // second default-selection strap
  input  wire logic              serial_port_select, // low enables the serial port
  input  wire logic              spi_clk,            // serial clock
  input  wire logic              spi_sdi,            // serial data in
  output logic                   spi_sdo,            // serial data out
  output logic                   spi_sdo_oe,         // serial data out enable
  input  wire logic [CONV_W-1:0] conv_word,          // converter output word
  input  wire logic [CONV_W-1:0] tx_word,            // transmit word from interface
  output logic [CONV_W-1:0]      tx_path_word,       // word into interpolation filters
  input  wire logic [PORT_W-1:0] rx_port_src,        // normal receive port data
  input  wire logic [PORT_W-1:0] tx_port_pins,       // transmit data port pins
  output logic [PORT_W-1:0]      rx_port_out,        // receive data port drive
  output logic                   rx_port_oe,         // receive port output enable
  output logic                   full_duplex,        // latched duplex selection
  output bias_settings_type      bias,               // effective bias settings
  output logic                   conv_low_power,     // converter low-power bit
  output logic                   analog_loop,        // analog loop-back active
  output logic                   cal_start           // calibration start pulse
);

  logic [DATA_W-1:0] adc_option_q;
  logic [DATA_W-1:0] test_mode_q;
  logic [DATA_W-1:0] rx_bias_q;
  logic              soft_reset_q;
  strap_type         strap_q;
  strap_type         strap_now;
  logic              hw_reset_n_q;
  logic              restore;
  logic              hw_low;

  assign strap_now = '{full_duplex: duplex_strap, config_sel: default_set_strap};
  assign hw_low    = !hw_reset_n;
  assign restore   = hw_low || soft_reset_q; // [RL7]

  // straps are caught while any reset holds, then kept steady
  always_ff @(posedge ref_clk) begin
    if (reset || restore) begin
      strap_q <= strap_now; // [RL5]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      full_duplex <= 1'b0;
    end else begin
      full_duplex <= strap_q.full_duplex; // [RL4]
    end
  end

  // reset pin edge tracking; a single low cycle is the shortest pulse seen
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hw_reset_n_q <= 1'b1;
      cal_start    <= 1'b0;
    end else begin
      hw_reset_n_q <= hw_reset_n;
      cal_start    <= hw_reset_n && !hw_reset_n_q; // [RL8] [RL12]
    end
  end

  // serial port
  spi_phase_type      phase_q;
  logic               spi_clk_q;
  logic [3:0]         bit_cnt_q;
  logic [DATA_W-1:0]  shift_in_q;
  logic               read_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [DATA_W-1:0]  shift_out_q;
  logic               sclk_rise;
  logic               sclk_fall;
  logic               port_on;
  logic [DATA_W-1:0]  header_next;
  logic               wr_strobe;
  logic [DATA_W-1:0]  wr_data;
  logic [DATA_W-1:0]  rd_data;

  assign port_on     = !serial_port_select; // [RL6]
  assign sclk_rise   = port_on && spi_clk && !spi_clk_q;
  assign sclk_fall   = port_on && !spi_clk && spi_clk_q;
  assign header_next = {shift_in_q[DATA_W-2:0], spi_sdi};
  assign wr_strobe   = sclk_rise && (phase_q == PH_DATA) && !read_q
                       && (bit_cnt_q == 4'(FRAME_BITS - 1));
  assign wr_data     = {shift_in_q[DATA_W-2:0], spi_sdi};

  always_comb begin
    rd_data = 8'h00;
    case (header_next[ADDR_W-1:0])
      SOFT_RESET_CONTROL_ADDR: begin
        rd_data = SOFT_RESET_DEFAULT;
        rd_data[SOFT_RESET_BIT]   = soft_reset_q;
        rd_data[STRAP_CONFIG_BIT] = strap_q.config_sel;
        rd_data[STRAP_DUPLEX_BIT] = strap_q.full_duplex;
      end
      ADC_POWER_OPTION_ADDR:  rd_data = adc_option_q;
      TEST_MODE_CONTROL_ADDR: rd_data = test_mode_q;
      RX_BIAS_ADJUST_ADDR:    rd_data = rx_bias_q;
      default:                rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      spi_clk_q <= 1'b0;
    end else begin
      spi_clk_q <= spi_clk;
    end
  end

  // a high select aborts any frame in progress
  always_ff @(posedge ref_clk) begin
    if (reset || !port_on) begin
      phase_q     <= PH_HEADER;
      bit_cnt_q   <= 4'h0;
      shift_in_q  <= 8'h00;
      read_q      <= 1'b0;
      addr_q      <= 7'h00;
      shift_out_q <= 8'h00;
    end else if (sclk_rise) begin
      shift_in_q <= header_next;
      bit_cnt_q  <= bit_cnt_q + 4'h1;
      case (phase_q)
        PH_HEADER: begin
          if (bit_cnt_q == 4'(HEADER_BITS - 1)) begin
            phase_q     <= PH_DATA;
            read_q      <= header_next[DATA_W-1];
            addr_q      <= header_next[ADDR_W-1:0];
            shift_out_q <= rd_data;
          end
        end
        PH_DATA: begin
          if (bit_cnt_q == 4'(FRAME_BITS - 1)) begin
            phase_q <= PH_HEADER;
          end
        end
        default: phase_q <= PH_HEADER;
      endcase
    end else if (sclk_fall && phase_q == PH_DATA && read_q && bit_cnt_q != 4'(HEADER_BITS)) begin
      shift_out_q <= {shift_out_q[DATA_W-2:0], 1'b0};
    end
  end

  // read data leaves msb first, changing on the falling serial edge
  always_ff @(posedge ref_clk) begin
    if (reset || !port_on) begin
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      spi_sdo    <= shift_out_q[DATA_W-1];
      spi_sdo_oe <= (phase_q == PH_DATA) && read_q;
    end
  end

  // register bank; the pin low reloads defaults every cycle it stays low
  always_ff @(posedge ref_clk) begin
    if (reset || restore) begin
      adc_option_q <= ADC_OPTION_DEFAULT[{strap_now.full_duplex, strap_now.config_sel}]; // [RL11]
      test_mode_q  <= TEST_MODE_DEFAULT;
      rx_bias_q    <= RX_BIAS_DEFAULT; // [RL2]
    end else if (wr_strobe) begin
      case (addr_q)
        ADC_POWER_OPTION_ADDR:  adc_option_q <= wr_data;
        TEST_MODE_CONTROL_ADDR: test_mode_q  <= wr_data;
        RX_BIAS_ADJUST_ADDR:    rx_bias_q    <= wr_data;
        default: ;
      endcase
    end
  end

  // the bit lives one cycle: it restores defaults, then reads back zero
  always_ff @(posedge ref_clk) begin
    if (reset || hw_low || soft_reset_q) begin
      soft_reset_q <= 1'b0; // [RL17]
    end else if (wr_strobe && addr_q == SOFT_RESET_CONTROL_ADDR) begin
      soft_reset_q <= wr_data[SOFT_RESET_BIT]; // [RL7]
    end
  end

  // bias and mode outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bias           <= '0;
      conv_low_power <= 1'b0;
      analog_loop    <= 1'b0;
    end else begin
      bias.coarse    <= rx_bias_q[COARSE_BIAS_MSB:COARSE_BIAS_LSB]; // [RL1]
      bias.fine      <= rx_bias_q[FINE_BIAS_MSB:FINE_BIAS_LSB];     // [RL1]
      bias.conv      <= adc_option_q[ADC_LOW_POWER_BIT] ? CONV_BIAS_LOW_POWER // [RL3]
                        : rx_bias_q[CONV_BIAS_MSB:CONV_BIAS_LSB];   // [RL1]
      conv_low_power <= adc_option_q[ADC_LOW_POWER_BIT];
      analog_loop    <= test_mode_q[ANALOG_LOOP_BIT];
    end
  end

  // transmit path feed: only system reset touches it, so filter contents
  // and the word in flight survive hardware and soft resets
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_path_word <= '0;
    end else begin
      tx_path_word <= test_mode_q[ANALOG_LOOP_BIT] ? conv_word : tx_word; // [RL14] [RL9]
    end
  end

  // receive port drive
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_port_out <= '0;
      rx_port_oe  <= 1'b0;
    end else begin
      rx_port_out <= test_mode_q[DIGITAL_LOOP_BIT] ? tx_port_pins : rx_port_src; // [RL15]
      rx_port_oe  <= !test_mode_q[RX_TRISTATE_BIT]; // [RL16]
    end
  end

endmodule

`default_nettype wire

// File: verification/frontend_ctrl_chk.sv
/*
  Concurrent checks on the front end control block, bound to its top.
  Assumes the single ref_clk domain and the synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module frontend_ctrl_chk
  import frontend_ctrl_pkg::*;
#(
  parameter int CONV_W = 12,
  parameter int PORT_W = 6
) (
  input wire logic              ref_clk,            // clock
  input wire logic              reset,              // sync reset
  input wire logic              hw_reset_n,         // reset pin
  input wire logic              duplex_strap,       // strap
  input wire logic              serial_port_select, // port select
  input wire logic              spi_sdo_oe,         // sdo enable
  input wire logic [CONV_W-1:0] conv_word,          // converter word
  input wire logic [CONV_W-1:0] tx_word,            // transmit word
  input wire logic [CONV_W-1:0] tx_path_word,       // filter input
  input wire logic [PORT_W-1:0] rx_port_src,        // receive source
  input wire logic [PORT_W-1:0] tx_port_pins,       // transmit pins
  input wire logic [PORT_W-1:0] rx_port_out,        // receive drive
  input wire logic              rx_port_oe,         // receive enable
  input wire logic              full_duplex,        // duplex state
  input wire bias_settings_type bias,               // bias settings
  input wire logic              conv_low_power,     // low-power bit
  input wire logic              analog_loop,        // analog loop
  input wire logic              cal_start           // calibration pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  tx_path_a: assert property (!$past(reset) |->
    tx_path_word == (analog_loop ? $past(conv_word) : $past(tx_word)))
    else $error("transmit path word from wrong source");
  rx_out_a: assert property (!$past(reset) |->
    rx_port_out == $past(tx_port_pins) || rx_port_out == $past(rx_port_src))
    else $error("receive port drive from wrong source");
  conv_bias_a: assert property (conv_low_power |-> bias.conv == CONV_BIAS_LOW_POWER)
    else $error("low-power bit without converter bias 011");
  hw_default_a: assert property (!hw_reset_n [*2] |=>
    bias.coarse == 3'h0 && bias.fine == 2'h0 && !analog_loop && rx_port_oe)
    else $error("defaults not loaded while reset pin low");
  duplex_sel_a: assert property (!hw_reset_n [*2] |=> full_duplex == $past(duplex_strap, 2))
    else $error("duplex state does not follow strap");
  cal_rise_a: assert property ($rose(hw_reset_n) |-> ##[1:2] cal_start)
    else $error("no calibration start after reset pin rise");
  cal_single_a: assert property (cal_start |=> !cal_start)
    else $error("calibration start longer than one cycle");
  cal_cause_a: assert property (cal_start && !$past(reset) && !$past(reset, 2) &&
    !$past(reset, 3) |-> !$past(hw_reset_n, 2) || !$past(hw_reset_n, 3))
    else $error("calibration start without reset pin pulse");
  port_off_a: assert property (serial_port_select [*2] |-> !spi_sdo_oe)
    else $error("serial output driven while port deselected");
endmodule

bind frontend_reset_bias_loopback_ctrl frontend_ctrl_chk #(.CONV_W(CONV_W), .PORT_W(PORT_W)) chk (
  .ref_clk, .reset, .hw_reset_n, .duplex_strap, .serial_port_select, .spi_sdo_oe, .conv_word,
  .tx_word, .tx_path_word, .rx_port_src, .tx_port_pins, .rx_port_out, .rx_port_oe,
  .full_duplex, .bias, .conv_low_power, .analog_loop, .cal_start);

`default_nettype wire

// File: verification/host_model.sv
/*
  Host side of the serial configuration port: frames of read flag, address
  and data, msb first. Assumes signals change just after ref_clk falls.
*/
`timescale 1ns/1ps
`default_nettype none

module host_model
  import frontend_ctrl_pkg::*;
(
  input  wire logic ref_clk,            // device clock
  input  wire logic spi_sdo,            // serial data out
  input  wire logic spi_sdo_oe,         // sdo enable
  output logic      spi_clk,            // serial clock
  output logic      spi_sdi,            // serial data in
  output logic      serial_port_select  // active low select
);
  initial begin
    spi_clk = 1'b0;
    spi_sdi = 1'b0;
    serial_port_select = 1'b1;
  end

  // three ref_clk per phase keeps margin over the two-cycle minimum
  task automatic xfer(input logic sel, input logic rd, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rdat);
    logic [FRAME_BITS-1:0] f;
    f = {rd, a, wd};
    rdat = '0;
    @(negedge ref_clk) serial_port_select = sel;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      spi_sdi = f[i];
      repeat (3) @(negedge ref_clk);
      // an undriven line reads as a wrong bit, never as a lucky match
      if (i < DATA_W) rdat[i] = spi_sdo_oe ? spi_sdo : ~spi_sdo;
      spi_clk = 1'b1;
      repeat (3) @(negedge ref_clk);
      spi_clk = 1'b0;
    end
    repeat (3) @(negedge ref_clk);
    serial_port_select = 1'b1;
    spi_sdi = ~spi_sdi;
    repeat (2) @(negedge ref_clk);
  endtask
endmodule

`default_nettype wire

// File: verification/testbench.sv
/*
  Self-checking bench for the front end control block: registers reached
  through the host model's serial frames. Assumes the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import frontend_ctrl_pkg::*;
  logic              ref_clk, reset, hw_reset_n, duplex_strap, default_set_strap;
  logic              serial_port_select, spi_clk, spi_sdi, spi_sdo, spi_sdo_oe;
  logic [11:0]       conv_word, tx_word, tx_path_word;
  logic [5:0]        rx_port_src, tx_port_pins, rx_port_out;
  logic              rx_port_oe, full_duplex, conv_low_power, analog_loop, cal_start;
  bias_settings_type bias;
  logic [7:0]        rdat;
  int                bad_count, num_checks, cycles, cal_seen, n;

  frontend_reset_bias_loopback_ctrl DUT (.ref_clk, .reset, .hw_reset_n, .duplex_strap,
    .default_set_strap, .serial_port_select, .spi_clk, .spi_sdi, .spi_sdo, .spi_sdo_oe,
    .conv_word, .tx_word, .tx_path_word, .rx_port_src, .tx_port_pins, .rx_port_out,
    .rx_port_oe, .full_duplex, .bias, .conv_low_power, .analog_loop, .cal_start);
  host_model host (.ref_clk, .spi_sdo, .spi_sdo_oe, .spi_clk, .spi_sdi, .serial_port_select);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cal_start === 1'b1) cal_seen++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    host.xfer(1'b0, 1'b0, a, d, rdat);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    host.xfer(1'b0, 1'b1, a, 8'h00, rdat);
    check(rdat, e);
  endtask

  task automatic close_out();
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {reset, hw_reset_n, duplex_strap, default_set_strap} = 4'h8;
    {conv_word, tx_word, rx_port_src, tx_port_pins} = {12'hA5C, 12'h3C1, 6'h15, 6'h2A};
    // power-up hold of the pin is scaled down to keep the run short
    repeat (15) @(negedge ref_clk);
    hw_reset_n = 1'b1;
    @(negedge ref_clk) reset = 1'b0;
    rdc(RX_BIAS_ADJUST_ADDR, 8'h00);
    rdc(7'h7F, 8'h00);
    for (int s = 0; s < 4; s++) begin
      {duplex_strap, default_set_strap} = s[1:0];
      n = cal_seen;
      @(negedge ref_clk) hw_reset_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      hw_reset_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      check(16'(cal_seen - n), 16'h1);
      check(full_duplex, s[1]);
      rdc(ADC_POWER_OPTION_ADDR, ADC_OPTION_DEFAULT[s]);
      rdc(SOFT_RESET_CONTROL_ADDR, {6'h00, s[0], s[1]});
    end
    wr(RX_BIAS_ADJUST_ADDR, 8'hB5);
    check(bias, 8'hB5);
    rdc(RX_BIAS_ADJUST_ADDR, 8'hB5);
    wr(ADC_POWER_OPTION_ADDR, 8'h10);
    check(bias, 8'hB3);
    check(conv_low_power, 1'b1);
    for (int m = 0; m < 4; m++) begin
      wr(TEST_MODE_CONTROL_ADDR, m < 3 ? 8'h80 >> m : 8'h00);
      check(tx_path_word, m == 0 ? conv_word : tx_word);
      check(analog_loop, m == 0);
      check(rx_port_out, m == 1 ? tx_port_pins : rx_port_src);
      check(rx_port_oe, m != 2);
    end
    wr(TEST_MODE_CONTROL_ADDR, 8'h80);
    @(negedge ref_clk) hw_reset_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    check(bias, 8'h00);
    check(tx_path_word, tx_word);
    hw_reset_n = 1'b1;
    wr(RX_BIAS_ADJUST_ADDR, 8'h5A);
    wr(ADC_POWER_OPTION_ADDR, 8'h10);
    n = cal_seen;
    wr(SOFT_RESET_CONTROL_ADDR, 8'h20);
    rdc(SOFT_RESET_CONTROL_ADDR, 8'h03);
    rdc(RX_BIAS_ADJUST_ADDR, 8'h00);
    rdc(ADC_POWER_OPTION_ADDR, ADC_OPTION_DEFAULT[3]);
    check(16'(cal_seen - n), 16'h0);
    host.xfer(1'b1, 1'b0, RX_BIAS_ADJUST_ADDR, 8'hFF, rdat);
    rdc(RX_BIAS_ADJUST_ADDR, 8'h00);
    close_out();
  end
endmodule

`default_nettype wire
